//--- hdl/sdhev_pkg.sv
// Package: register map, field positions, states and timing of the error/voltage-switch block
package sdhev_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CLK_GATE = 12'h010;
  localparam logic [11:0] OFF_DTO = 12'h014;
  localparam logic [11:0] OFF_MASK = 12'h024;
  localparam logic [11:0] OFF_CMD = 12'h02C;
  localparam logic [11:0] OFF_RAW = 12'h044;
  localparam logic [11:0] OFF_STATUS = 12'h048;
  localparam logic [11:0] OFF_TCB = 12'h05C;
  localparam logic [11:0] OFF_FIFO = 12'h200;
  // ==========================================================
  // Field positions
  localparam int CTRL_INT_EN = 0;
  localparam int CTRL_SD_MODE = 1;
  localparam int CTRL_BUS4 = 2;
  localparam int CLK_EN_BIT = 0;
  localparam int CLK_LOWPWR_BIT = 16;
  localparam int CMD_START_BIT = 31;
  localparam int CMD_VOLT_BIT = 28;
  localparam int RAW_RE = 1;
  localparam int RAW_CD = 2;
  localparam int RAW_DCRC = 7;
  localparam int RAW_DRTO = 9;
  localparam int RAW_HTO = 10;
  localparam int RAW_FRUN = 11;
  localparam int RAW_HLE = 12;
  localparam int RAW_SBE = 13;
  localparam int RAW_EBE = 15;
  localparam int RAW_VSI = 16;
  // ==========================================================
  // Reset values
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [23:0] DTO_RST = 24'hFF_FFFF;
  // ==========================================================
  // Timing: host starvation window
  localparam int CLK_PERIOD_NS = 8;
  localparam int STARVE_TIME_NS = 4000;
  localparam int STARVE_CYC = STARVE_TIME_NS / CLK_PERIOD_NS;
  localparam int HTO_W = 10;
  // ==========================================================
  // Voltage switch sequencer
  typedef enum logic [2:0] {
    VS_IDLE = 3'b000,
    VS_RESP = 3'b001,
    VS_LOW = 3'b010,
    VS_OFF = 3'b011,
    VS_ON = 3'b100,
    VS_HIGH = 3'b101
  } sdhev_vs_type;
endpackage

//--- hdl/sdhev_lines_if.sv
// Interface: synchronised card line levels and card clock edge
interface sdhev_lines_if;
  logic cmd_lvl; // CMD level, core domain
  logic [3:0] dat_lvl; // DAT levels, core domain
  logic clk_rise; // One-cycle pulse per card clock rise
  modport src (output cmd_lvl, output dat_lvl, output clk_rise);
  modport dst (input cmd_lvl, input dat_lvl, input clk_rise);
endinterface

//--- hdl/sdhev_line_sync.sv
// Two-stage synchroniser for CMD, DAT and card clock pins
module sdhev_line_sync (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cmd_in, // CMD pin level
  input wire logic [3:0] dat_in, // DAT pin levels
  input wire logic clk_in, // Card bus clock pin
  sdhev_lines_if.src lines // Synchronised levels
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic clk_d;
  } sdhev_sync_type;
  sdhev_sync_type st_r, st_nxt;
  // ==========================================================
  // Stage one feeds only stage two; edge detect looks at stage two
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {clk_in, dat_in, cmd_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.clk_d = st_r.s2[5];
  end
  // Lines idle high, so reset to high keeps false low events away
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r <= '{s1: 6'h1F, s2: 6'h1F, clk_d: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign lines.cmd_lvl = st_r.s2[0];
  assign lines.dat_lvl = st_r.s2[4:1];
  assign lines.clk_rise = st_r.s2[5] & ~st_r.clk_d;
endmodule // sdhev_line_sync

//--- hdl/sdhev_top.sv
// Error reporting and voltage-switch detection with a Wishbone register slave
// Operation
// - Every detected error sets a bit in the raw status register at 0x44.
// - After reset the global interrupt enable and all 32 mask bits are zero.
// - Missing data start bit within timeout raises data timeout; byte counter stays readable.
// - An error during response reception sets the response error flag.
// - Data CRC, start bit and end bit errors flag on any block.
// - Command start while buffer is full raises hardware-locked error; new command dropped.
// - Write to full FIFO sets overrun; read from empty FIFO sets underrun.
// - Software not serving the FIFO within the timeout raises starvation timeout.
// - Negative CRC token sets data CRC error; transmission still continues.
// - Voltage switch only in SD mode with 4-bit bus; 1.8 V is sticky.
// - Software clears the low-power clock bit before the switch; clock runs freely.
// - The switch command response does not raise command done.
// - After that response, any low CMD or DAT line raises the switch event.
// - With clock restarted, all lines high raise switch event and command done.
module sdhev_top (
  input wire logic core_clk, // Core clock, 125 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [11:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic cmd_pin_in, // CMD line level from pad
  input wire logic [3:0] dat_pin_in, // DAT line levels from pad
  input wire logic card_bus_clock_in, // Card bus clock seen at pad
  input wire logic cmd_taken, // Command engine loaded the buffer
  input wire logic rsp_done, // Response received pulse
  input wire logic rsp_err, // Response error pulse
  input wire logic data_wait, // Data path waiting for a start bit
  input wire logic data_crc_err, // Data CRC mismatch pulse
  input wire logic start_bit_err, // Start bit missing pulse
  input wire logic end_bit_err, // End bit missing pulse
  input wire logic crc_token_neg, // Negative CRC status token pulse
  input wire logic byte_done, // One byte transferred pulse
  input wire logic xfer_active, // Data transfer in progress
  input wire logic xfer_read, // Transfer direction is read
  input wire logic fifo_full, // FIFO full flag
  input wire logic fifo_empty, // FIFO empty flag
  input wire logic [31:0] fifo_rdata, // FIFO head word
  output logic fifo_push, // Software FIFO write pulse
  output logic fifo_pop, // Software FIFO read pulse
  output logic [31:0] fifo_wdata, // Word to push
  output logic cmd_valid, // Command buffer holds a command
  output logic [31:0] cmd_word, // Buffered command word
  output logic card_clock_gate, // Card clock enable
  output logic card_clock_low_power, // Card clock auto-stop enable
  output logic signaling_18, // 1.8 V signalling active
  output logic irq // Masked, enabled interrupt level
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] raw;
    logic [31:0] mask;
    logic int_en;
    logic sd_mode;
    logic bus4;
    logic clk_en;
    logic low_pwr;
    logic [23:0] dto_lim;
    logic [23:0] dto_cnt;
    logic [sdhev_pkg::HTO_W-1:0] hto_cnt;
    logic hto_done;
    logic cmd_pend;
    logic [31:0] cmd_word;
    logic [31:0] tcb;
    logic sig18;
    sdhev_pkg::sdhev_vs_type vs;
    logic push;
    logic pop;
    logic [31:0] wdata;
    logic irq;
  } sdhev_state_type;

  sdhev_state_type s_r, s_nxt;
  sdhev_lines_if lines ();

  // ==========================================================
  // Pin synchronisers
  sdhev_line_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .cmd_in(cmd_pin_in),
    .dat_in(dat_pin_in),
    .clk_in(card_bus_clock_in),
    .lines(lines.src)
  );

  // ==========================================================
  // Helpers
  // Word address match
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  logic req;
  logic wr;
  logic rd;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [31:0] wmask;
  logic [31:0] ctrl_w;
  logic [31:0] clk_w;
  logic [31:0] status_w;
  logic [31:0] ctrl_m;
  logic [31:0] clk_m;
  logic [31:0] dto_m;
  logic line_low;
  logic line_high;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & s_r.ack;
  assign rd = req & ~wb_we_i & s_r.ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign line_low = ~lines.cmd_lvl | ~(&lines.dat_lvl);
  assign line_high = lines.cmd_lvl & (&lines.dat_lvl);

  // Readback views of packed control bits
  always_comb begin
    ctrl_w = 32'h0000_0000;
    ctrl_w[sdhev_pkg::CTRL_INT_EN] = s_r.int_en;
    ctrl_w[sdhev_pkg::CTRL_SD_MODE] = s_r.sd_mode;
    ctrl_w[sdhev_pkg::CTRL_BUS4] = s_r.bus4;
    clk_w = 32'h0000_0000;
    clk_w[sdhev_pkg::CLK_EN_BIT] = s_r.clk_en;
    clk_w[sdhev_pkg::CLK_LOWPWR_BIT] = s_r.low_pwr;
    status_w = {23'h00_0000, s_r.vs, s_r.sig18, s_r.cmd_pend, 2'h0, fifo_full, fifo_empty};
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    set_bits = 32'h0000_0000;
    clr_bits = 32'h0000_0000;
    s_nxt.push = 1'b0;
    s_nxt.pop = 1'b0;
    // Merged write views, so the readback views keep a single driver
    ctrl_m = merge(ctrl_w, wb_dat_i, wb_sel_i);
    clk_m = merge(clk_w, wb_dat_i, wb_sel_i);
    dto_m = merge({8'h00, s_r.dto_lim}, wb_dat_i, wb_sel_i);

    // Ack one cycle after the request; effects land on the ack edge
    s_nxt.ack = req & ~s_r.ack;
    if (req & ~s_r.ack) begin
      if (hit(wb_adr_i, sdhev_pkg::OFF_CTRL)) begin
        s_nxt.rdat = ctrl_w;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_CLK_GATE)) begin
        s_nxt.rdat = clk_w;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_DTO)) begin
        s_nxt.rdat = {8'h00, s_r.dto_lim};
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_MASK)) begin
        s_nxt.rdat = s_r.mask;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_CMD)) begin
        s_nxt.rdat = s_r.cmd_word;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_RAW)) begin
        s_nxt.rdat = s_r.raw;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_STATUS)) begin
        s_nxt.rdat = status_w;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_TCB)) begin
        s_nxt.rdat = s_r.tcb;
      end else if (hit(wb_adr_i, sdhev_pkg::OFF_FIFO)) begin
        s_nxt.rdat = fifo_rdata;
      end else begin
        s_nxt.rdat = 32'h0000_0000; // Unmapped reads zero
      end
    end

    // Register writes
    if (wr) begin
      if (hit(wb_adr_i, sdhev_pkg::OFF_CTRL)) begin
        s_nxt.int_en = ctrl_m[sdhev_pkg::CTRL_INT_EN];
        s_nxt.sd_mode = ctrl_m[sdhev_pkg::CTRL_SD_MODE];
        s_nxt.bus4 = ctrl_m[sdhev_pkg::CTRL_BUS4];
      end
      if (hit(wb_adr_i, sdhev_pkg::OFF_CLK_GATE)) begin
        s_nxt.clk_en = clk_m[sdhev_pkg::CLK_EN_BIT];
        s_nxt.low_pwr = clk_m[sdhev_pkg::CLK_LOWPWR_BIT];
      end
      if (hit(wb_adr_i, sdhev_pkg::OFF_DTO)) begin
        s_nxt.dto_lim = dto_m[23:0];
      end
      if (hit(wb_adr_i, sdhev_pkg::OFF_MASK)) begin
        s_nxt.mask = merge(s_r.mask, wb_dat_i, wb_sel_i);
      end
      if (hit(wb_adr_i, sdhev_pkg::OFF_RAW)) begin
        clr_bits = wb_dat_i & wmask; // Write one to clear
      end
      if (hit(wb_adr_i, sdhev_pkg::OFF_CMD) && wb_sel_i[3] && wb_dat_i[sdhev_pkg::CMD_START_BIT]) begin
        // A second command cannot overwrite one not yet loaded
        if (s_r.cmd_pend && !cmd_taken) begin
          set_bits[sdhev_pkg::RAW_HLE] = 1'b1;
        end else begin
          s_nxt.cmd_pend = 1'b1;
          s_nxt.cmd_word = merge(s_r.cmd_word, wb_dat_i, wb_sel_i);
        end
      end
      if (hit(wb_adr_i, sdhev_pkg::OFF_FIFO)) begin
        if (fifo_full) begin
          set_bits[sdhev_pkg::RAW_FRUN] = 1'b1;
        end else begin
          s_nxt.push = 1'b1;
          s_nxt.wdata = wb_dat_i;
        end
      end
    end
    if (rd && hit(wb_adr_i, sdhev_pkg::OFF_FIFO)) begin
      if (fifo_empty) begin
        set_bits[sdhev_pkg::RAW_FRUN] = 1'b1;
      end else begin
        s_nxt.pop = 1'b1;
      end
    end

    // Command hand-off; a marked switch command arms the sequencer
    if (cmd_taken && s_r.cmd_pend) begin
      s_nxt.cmd_pend = 1'b0;
      if (s_r.cmd_word[sdhev_pkg::CMD_VOLT_BIT] && s_r.sd_mode && s_r.bus4 && !s_r.sig18) begin
        s_nxt.vs = sdhev_pkg::VS_RESP;
      end
    end

    // Response and data errors
    if (rsp_err) begin
      set_bits[sdhev_pkg::RAW_RE] = 1'b1;
    end
    if (data_crc_err || crc_token_neg) begin
      set_bits[sdhev_pkg::RAW_DCRC] = 1'b1;
    end
    if (start_bit_err) begin
      set_bits[sdhev_pkg::RAW_SBE] = 1'b1;
    end
    if (end_bit_err) begin
      set_bits[sdhev_pkg::RAW_EBE] = 1'b1;
    end
    if (byte_done) begin
      s_nxt.tcb = s_r.tcb + 32'h0000_0001;
    end

    // Data timeout counted in card clocks while DAT0 stays high
    if (!data_wait || !lines.dat_lvl[0]) begin
      s_nxt.dto_cnt = 24'h00_0000;
    end else if (lines.clk_rise && s_r.dto_cnt != s_r.dto_lim) begin
      s_nxt.dto_cnt = s_r.dto_cnt + 24'h00_0001;
      if (s_r.dto_cnt + 24'h00_0001 == s_r.dto_lim) begin
        set_bits[sdhev_pkg::RAW_DRTO] = 1'b1;
      end
    end

    // Starvation: fires once per stall, rearms when software acts
    if (xfer_active && (xfer_read ? fifo_full : fifo_empty)) begin
      if (!s_r.hto_done) begin
        if (s_r.hto_cnt == sdhev_pkg::HTO_W'(sdhev_pkg::STARVE_CYC - 1)) begin
          set_bits[sdhev_pkg::RAW_HTO] = 1'b1;
          s_nxt.hto_done = 1'b1;
        end else begin
          s_nxt.hto_cnt = s_r.hto_cnt + sdhev_pkg::HTO_W'(1);
        end
      end
    end else begin
      s_nxt.hto_cnt = '0;
      s_nxt.hto_done = 1'b0;
    end

    // Voltage switch sequencer
    case (s_r.vs)
      sdhev_pkg::VS_IDLE: begin
        if (rsp_done) begin
          set_bits[sdhev_pkg::RAW_CD] = 1'b1;
        end
      end
      sdhev_pkg::VS_RESP: begin
        if (rsp_err) begin
          s_nxt.vs = sdhev_pkg::VS_IDLE;
        end else if (rsp_done) begin
          s_nxt.vs = sdhev_pkg::VS_LOW;
        end
      end
      sdhev_pkg::VS_LOW: begin
        if (line_low) begin
          set_bits[sdhev_pkg::RAW_VSI] = 1'b1;
          s_nxt.vs = sdhev_pkg::VS_OFF;
        end
      end
      sdhev_pkg::VS_OFF: begin
        if (!s_r.clk_en) begin
          s_nxt.vs = sdhev_pkg::VS_ON;
        end
      end
      sdhev_pkg::VS_ON: begin
        // Lines are only judged after the card has seen a clock again
        if (s_r.clk_en && lines.clk_rise) begin
          s_nxt.vs = sdhev_pkg::VS_HIGH;
        end
      end
      sdhev_pkg::VS_HIGH: begin
        if (line_high) begin
          set_bits[sdhev_pkg::RAW_VSI] = 1'b1;
          set_bits[sdhev_pkg::RAW_CD] = 1'b1;
          s_nxt.sig18 = 1'b1;
          s_nxt.vs = sdhev_pkg::VS_IDLE;
        end
      end
      default: begin
        s_nxt.vs = sdhev_pkg::VS_IDLE;
      end
    endcase

    // Set wins over a same-cycle software clear
    s_nxt.raw = (s_r.raw & ~clr_bits) | set_bits;
    s_nxt.irq = s_r.int_en & (|(s_nxt.raw & s_nxt.mask));
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.mask <= sdhev_pkg::MASK_RST;
      s_r.dto_lim <= sdhev_pkg::DTO_RST;
      s_r.vs <= sdhev_pkg::VS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign fifo_push = s_r.push;
  assign fifo_pop = s_r.pop;
  assign fifo_wdata = s_r.wdata;
  assign cmd_valid = s_r.cmd_pend;
  assign cmd_word = s_r.cmd_word;
  assign card_clock_gate = s_r.clk_en;
  assign card_clock_low_power = s_r.low_pwr;
  assign signaling_18 = s_r.sig18;
  assign irq = s_r.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  reset_clear_a: assert property ($past(!nrst) |-> s_r.mask == 32'h0000_0000 && !s_r.int_en)
    else $error("mask or interrupt enable not cleared by reset");
  lock_drop_a: assert property (wr && hit(wb_adr_i, sdhev_pkg::OFF_CMD) && wb_sel_i[3]
      && wb_dat_i[31] && s_r.cmd_pend && !cmd_taken
      |=> s_r.raw[sdhev_pkg::RAW_HLE] && $stable(s_r.cmd_word))
    else $error("locked command not flagged or overwritten");
  overrun_flag_a: assert property (wr && hit(wb_adr_i, sdhev_pkg::OFF_FIFO) && fifo_full
      |=> s_r.raw[sdhev_pkg::RAW_FRUN] && !fifo_push)
    else $error("overrun not flagged");
  underrun_flag_a: assert property (rd && hit(wb_adr_i, sdhev_pkg::OFF_FIFO) && fifo_empty
      |=> s_r.raw[sdhev_pkg::RAW_FRUN] && !fifo_pop)
    else $error("underrun not flagged");
  switch_resp_a: assert property (s_r.vs == sdhev_pkg::VS_RESP && rsp_done && !rsp_err
      && !s_r.raw[sdhev_pkg::RAW_CD] |=> !s_r.raw[sdhev_pkg::RAW_CD])
    else $error("command done raised for switch response");
  low_event_a: assert property (s_r.vs == sdhev_pkg::VS_LOW && line_low
      |=> s_r.raw[sdhev_pkg::RAW_VSI] ##1 s_r.vs != sdhev_pkg::VS_LOW)
    else $error("low lines not reported");
  high_event_a: assert property (s_r.vs == sdhev_pkg::VS_HIGH && line_high
      |=> s_r.raw[sdhev_pkg::RAW_VSI] && s_r.raw[sdhev_pkg::RAW_CD] && signaling_18)
    else $error("high lines not reported");
  crc_token_a: assert property (crc_token_neg |=> s_r.raw[sdhev_pkg::RAW_DCRC])
    else $error("negative token not flagged");
  sticky_18v_a: assert property (signaling_18 |=> signaling_18)
    else $error("1.8 V state dropped");
  w1c_keep_a: assert property (rsp_err |=> s_r.raw[sdhev_pkg::RAW_RE] ##1 (s_r.raw[sdhev_pkg::RAW_RE]
      || $past(wr && hit(wb_adr_i, sdhev_pkg::OFF_RAW) && wb_sel_i[0]
      && wb_dat_i[sdhev_pkg::RAW_RE])))
    else $error("response error lost");
endmodule // sdhev_top

//--- bench/sdhev_card_model.sv
// Card model: gated card bus clock and the card's side of the voltage switch
module sdhev_card_model (
  input wire logic clk_gate, // Card clock enable from the host
  input wire logic sw_go, // Card has answered the switch command
  output logic card_clk, // Card bus clock, still while gated off
  output logic cmd_o, // CMD level, pulled up when released
  output logic [3:0] dat_o // DAT levels, pulled up when released
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Clock
  // 125 ns period, held low whenever the host gates it off
  initial begin
    card_clk = 1'b0;
    forever begin
      #62.5;
      card_clk = clk_gate ? ~card_clk : 1'b0;
    end
  end
  // ==========================================================
  // Switch sequence
  // Lines idle high through their pull-ups, so a release reads as high
  initial begin
    cmd_o = 1'b1;
    dat_o = 4'hF;
    @(posedge sw_go);
    cmd_o = 1'b0;
    dat_o = 4'h0;
    @(negedge clk_gate);
    @(posedge clk_gate);
    @(posedge card_clk);
    cmd_o = 1'b1;
    dat_o = 4'hF;
  end
endmodule // sdhev_card_model

//--- bench/tb_sdhev_top.sv
// Testbench: error flags, FIFO, timeouts and voltage switch of the block
module tb_sdhev_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, sw_go = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [31:0] wb_wdat = 32'h0, fifo_rdata = 32'h0, q, w1, last_w;
  logic [7:0] ev = 8'h00;
  logic data_wait = 1'b0, xfer_active = 1'b0, fifo_full = 1'b0, fifo_empty = 1'b1, xfer_rd = 1'b0;
  logic [31:0] wb_dat_o, fifo_wdata, cmd_word;
  logic wb_ack_o, fifo_push, fifo_pop, cmd_valid, card_clock_gate, low_pwr, sig18, irq;
  logic card_clk, cmd_line;
  logic [3:0] dat_line;
  int mismatches = 0, tests_run = 0, cycles = 0, pushes = 0, pops = 0, n;
  int ebit [8] = '{0, sdhev_pkg::RAW_RE, sdhev_pkg::RAW_DCRC, sdhev_pkg::RAW_SBE,
    sdhev_pkg::RAW_EBE, sdhev_pkg::RAW_DCRC, 0, 0};
  always #4 core_clk = ~core_clk;
  sdhev_card_model i_card (.clk_gate(card_clock_gate), .sw_go(sw_go), .card_clk(card_clk),
    .cmd_o(cmd_line), .dat_o(dat_line));
  sdhev_top i_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_pin_in(cmd_line), .dat_pin_in(dat_line),
    .card_bus_clock_in(card_clk), .cmd_taken(ev[7]), .rsp_done(ev[0]), .rsp_err(ev[1]),
    .data_wait(data_wait), .data_crc_err(ev[2]), .start_bit_err(ev[3]),
    .end_bit_err(ev[4]), .crc_token_neg(ev[5]), .byte_done(ev[6]),
    .xfer_active(xfer_active), .xfer_read(xfer_rd), .fifo_full(fifo_full),
    .fifo_empty(fifo_empty), .fifo_rdata(fifo_rdata), .fifo_push(fifo_push),
    .fifo_pop(fifo_pop), .fifo_wdata(fifo_wdata), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .card_clock_gate(card_clock_gate),
    .card_clock_low_power(low_pwr), .signaling_18(sig18), .irq(irq));
  // ==========================================================
  // Checking and bus tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] bitv(input int b);
    return 32'h1 << b;
  endfunction
  // Classic cycle: hold the request until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    // Only ack or the run limit ends this wait
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic raw_bit(input int b, input logic e);
    wb(1'b0, sdhev_pkg::OFF_RAW, 32'h0);
    chk("raw_bit", {31'h0, q[b]}, {31'h0, e});
  endtask
  // Polls rather than waits a fixed time: card clock and sync latency are loose
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      wb(1'b0, sdhev_pkg::OFF_RAW, 32'h0);
      k++;
    end while (q[b] !== 1'b1 && k < 60);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev <= 8'h00;
    @(posedge core_clk);
  endtask
  // FIFO strobe monitor and run limit
  always @(posedge core_clk) begin
    pushes <= pushes + (fifo_push === 1'b1);
    pops <= pops + (fifo_pop === 1'b1);
    if (fifo_push === 1'b1) last_w <= fifo_wdata;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h6eee));
    fifo_rdata <= $urandom;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, sdhev_pkg::OFF_MASK, 32'h0);
    chk("mask", q, 32'h0);
    wb(1'b0, sdhev_pkg::OFF_CTRL, 32'h0);
    chk("int_en", {31'h0, q[0]}, 32'h0);
    wb(1'b0, 12'h300, 32'h0);
    chk("unmapped", q, 32'h0);
    // Each error pulse sets its flag; write-one clears it
    for (int i = 1; i < 6; i++) begin
      pulse(i);
      raw_bit(ebit[i], 1'b1);
      wb(1'b1, sdhev_pkg::OFF_RAW, bitv(ebit[i]));
      raw_bit(ebit[i], 1'b0);
    end
    wb(1'b1, sdhev_pkg::OFF_CTRL, 32'h1);
    wb(1'b1, sdhev_pkg::OFF_MASK, bitv(sdhev_pkg::RAW_RE));
    pulse(1);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_RE));
    chk("irq_clr", {31'h0, irq}, 32'h0);
    // Second start while the buffer is full is dropped
    w1 = {4'h8, 28'($urandom)};
    wb(1'b1, sdhev_pkg::OFF_CMD, w1);
    chk("cmd_valid", {31'h0, cmd_valid}, 32'h1);
    wb(1'b1, sdhev_pkg::OFF_CMD, w1 ^ 32'h0000_FFFF);
    raw_bit(sdhev_pkg::RAW_HLE, 1'b1);
    chk("cmd_word", cmd_word, w1);
    pulse(7);
    wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_HLE));
    // FIFO overrun and underrun
    w1 = $urandom;
    wb(1'b1, sdhev_pkg::OFF_FIFO, w1);
    // The monitor updates last_w by NBA at the edge that closes the push cycle
    @(posedge core_clk);
    chk("push_data", last_w, w1);
    fifo_full <= 1'b1;
    wb(1'b1, sdhev_pkg::OFF_FIFO, ~w1);
    chk("pushes", pushes, 1);
    raw_bit(sdhev_pkg::RAW_FRUN, 1'b1);
    fifo_full <= 1'b0;
    wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_FRUN));
    fifo_empty <= 1'b0;
    wb(1'b0, sdhev_pkg::OFF_FIFO, 32'h0);
    chk("fifo_rd", q, fifo_rdata);
    fifo_empty <= 1'b1;
    wb(1'b0, sdhev_pkg::OFF_FIFO, 32'h0);
    chk("pops", pops, 1);
    raw_bit(sdhev_pkg::RAW_FRUN, 1'b1);
    wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_FRUN));
    // Starvation for 500 cycles: empty FIFO on a write, then full FIFO on a read
    for (int j = 0; j < 2; j++) begin
      xfer_rd <= j[0];
      fifo_full <= j[0];
      fifo_empty <= !j[0];
      xfer_active <= 1'b1;
      repeat (470) @(posedge core_clk);
      raw_bit(sdhev_pkg::RAW_HTO, 1'b0);
      repeat (40) @(posedge core_clk);
      raw_bit(sdhev_pkg::RAW_HTO, 1'b1);
      xfer_active <= 1'b0;
      wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_HTO));
    end
    xfer_rd <= 1'b0;
    fifo_full <= 1'b0;
    fifo_empty <= 1'b1;
    // Data timeout with a short limit; byte count stays readable
    n = 1 + $urandom % 8;
    repeat (n) pulse(6);
    wb(1'b1, sdhev_pkg::OFF_DTO, 32'h4);
    wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h1);
    data_wait <= 1'b1;
    poll(sdhev_pkg::RAW_DRTO);
    raw_bit(sdhev_pkg::RAW_DRTO, 1'b1);
    data_wait <= 1'b0;
    wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h0);
    wb(1'b0, sdhev_pkg::OFF_TCB, 32'h0);
    chk("tcb", q, n);
    wb(1'b1, sdhev_pkg::OFF_RAW, 32'hFFFF_FFFF);
    // Switch outside SD 4-bit mode acts as an ordinary command
    wb(1'b1, sdhev_pkg::OFF_CMD, bitv(31) | bitv(28));
    pulse(7);
    pulse(0);
    raw_bit(sdhev_pkg::RAW_CD, 1'b1);
    wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_CD));
    // Full voltage switch sequence
    wb(1'b1, sdhev_pkg::OFF_CTRL, 32'h7);
    wb(1'b1, sdhev_pkg::OFF_MASK, bitv(sdhev_pkg::RAW_VSI));
    wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h0001_0001);
    chk("low_power_on", {31'h0, low_pwr}, 32'h1);
    wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h1);
    chk("low_power", {31'h0, low_pwr}, 32'h0);
    chk("clk_gate", {31'h0, card_clock_gate}, 32'h1);
    // Switch only when the card reports itself ready and able to switch
    w1 = bitv(31) | bitv(30) | bitv(24);
    if (w1[31] && w1[24]) wb(1'b1, sdhev_pkg::OFF_CMD, bitv(31) | bitv(28));
    pulse(7);
    pulse(0);
    raw_bit(sdhev_pkg::RAW_CD, 1'b0);
    raw_bit(sdhev_pkg::RAW_VSI, 1'b0);
    sw_go <= 1'b1;
    poll(sdhev_pkg::RAW_VSI);
    raw_bit(sdhev_pkg::RAW_VSI, 1'b1);
    chk("irq_vsi", {31'h0, irq}, 32'h1);
    wb(1'b1, sdhev_pkg::OFF_RAW, bitv(sdhev_pkg::RAW_VSI));
    wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h0);
    wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h1);
    poll(sdhev_pkg::RAW_VSI);
    // No high lines in time: stop the card clock before a power cycle
    if (q[sdhev_pkg::RAW_VSI] !== 1'b1) wb(1'b1, sdhev_pkg::OFF_CLK_GATE, 32'h0);
    raw_bit(sdhev_pkg::RAW_VSI, 1'b1);
    raw_bit(sdhev_pkg::RAW_CD, 1'b1);
    chk("sig18", {31'h0, sig18}, 32'h1);
    report_and_stop();
  end
endmodule // tb_sdhev_top
